// [pmf_map.svh]
// register offsets, field positions and reset values of the fault and regulator configuration bank
// included by the register bank module only, not by the sticky flags module; definitions only
`ifndef PMF_MAP_SVH
`define PMF_MAP_SVH

`define PMF_FAULT_OFS 8'h05
`define PMF_CID_OFS 8'h06
`define PMF_SHARED_OFS 8'h07
`define PMF_CH0_OFS 8'h08

`define PMF_UV_BIT 2
`define PMF_OV_BIT 1
`define PMF_TH_BIT 0
`define PMF_STEP_LSB 2
`define PMF_STEP_MSB 5
`define PMF_DRV_LSB 0
`define PMF_DRV_MSB 1

`define PMF_SHARED_RST 8'h00
`define PMF_CH0_RST 8'h00
`define PMF_COARSE_MAX_CODE 8'hc8
`define PMF_BASE_UNITS 9'h028
`define PMF_BYTE_BITS 4'h8

`endif

// [pmf_pkg.sv]
// types shared by the fault and regulator configuration bank
// no constants here; offsets and values live in pmf_map.svh
`default_nettype none

package pmf_pkg;

  typedef enum logic [3:0]
  {
    PMF_IDLE      = 4'h0,
    PMF_ADDR      = 4'h1,
    PMF_ADDR_ACK  = 4'h3,
    PMF_REG       = 4'h2,
    PMF_REG_ACK   = 4'h6,
    PMF_WDATA     = 4'h7,
    PMF_WDATA_ACK = 4'h5,
    PMF_RDATA     = 4'h4,
    PMF_RDATA_ACK = 4'hc
  } pmf_state_e;

  typedef struct packed
  {
    logic undervolt;
    logic overvolt;
    logic thermal;
  } pmf_fault_s;

  typedef struct packed
  {
    pmf_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic scl_p;
    logic sda_p;
    logic sda_o;
    logic sda_oen;
    logic [3:0] step_sel;
    logic [1:0] drv;
    logic [7:0] ch0_code;
    logic ch0_step;
    logic [7:0] ch0_applied;
    logic [8:0] ch0_units;
  } pmf_bank_s;

endpackage

`default_nettype wire

// [pmf_sticky_flags.sv]
// sticky event flags that clear on a read strobe
// assumes the clear strobe is one cycle wide and the conditions are synchronous levels
`timescale 1ns/1ps
`default_nettype none

module pmf_sticky_flags
#(
  parameter int WIDTH = 3
)
(
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic clr_i,
  output logic [WIDTH-1:0] flag_o
);

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  // a condition present in the clearing cycle wins over the clear
  always_comb
  begin
    flag_d = set_i | (flag_q & {WIDTH{~clr_i}});
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      flag_q <= '0;
    end
    else if (CE_I)
    begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule

`default_nettype wire

// [pmf_regbank.sv]
// fault flags, configuration identification and regulator configuration behind an i2c target
// assumes scl and sda arrive synchronous to the system clock; sda is open drain outside
//
// Contract
// - Undervoltage flag, bit 2, sets on input undervoltage and holds until read.
// - Overvoltage flag, bit 1, sets on input overvoltage and holds until read.
// - Thermal overload flag, bit 0, sets on overtemperature and holds until read.
// - Reading the fault register clears flags; they return only on a new fault. Here a fault still present at the read keeps its flag.
// - Configuration identification in bits 4:0 is read only, follows factory configuration.
// - Shared config holds step selects: ch3 bit5, ch2 bit4, ch1 bit3, ch0 bit2.
// - Step select zero means 25.0 mV steps, one means 12.5 mV steps.
// - New step size reaches the channel only with the next target code write.
// - Top of range is 5.500 V coarse and 3.6875 V fine.
// - Two-bit drive trim in bits 1:0, shared, code zero fastest, higher slower.
// - Channel 0 target equals 0.5 V plus code times step; coarse codes above full scale reserved.
`timescale 1ns/1ps
`default_nettype none
`include "pmf_map.svh"

module pmf_regbank
#(
  // target address on the serial bus; value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OEN_O,
  input wire pmf_pkg::pmf_fault_s FAULT_COND_I,
  input wire logic [4:0] CONFIG_ID_I,
  output pmf_pkg::pmf_fault_s FAULT_FLAGS_O,
  output logic [3:0] STEP_SELECT_O,
  output logic [1:0] DRIVE_TRIM_O,
  output logic CH0_STEP_O,
  output logic [7:0] CH0_TARGET_CODE_O,
  output logic [8:0] CH0_TARGET_UNITS_O
);

  localparam pmf_pkg::pmf_bank_s BANK_RST = '{
    st: pmf_pkg::PMF_IDLE,
    cnt: 4'h0,
    sh: 8'h00,
    tx: 8'h00,
    ptr: 8'h00,
    rw: 1'b0,
    nack: 1'b0,
    scl_p: 1'b1,
    sda_p: 1'b1,
    sda_o: 1'b0,
    sda_oen: 1'b1,
    step_sel: 4'(`PMF_SHARED_RST >> `PMF_STEP_LSB),
    drv: 2'h0,
    ch0_code: `PMF_CH0_RST,
    ch0_step: 1'b0,
    ch0_applied: `PMF_CH0_RST,
    ch0_units: `PMF_BASE_UNITS
  };

  pmf_pkg::pmf_bank_s q;
  pmf_pkg::pmf_bank_s d;
  pmf_pkg::pmf_fault_s flags;
  logic rd_clr;
  logic [7:0] rd_addr;
  logic [7:0] rd_byte;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] wr_applied;

  ////////////////////////////////////////////////////////////////////////////
  // fault flags

  pmf_sticky_flags #(
    .WIDTH(3)
  ) u_flags (
    .CLK_SYS_I(CLK_SYS_I),
    .RESETN_I(RESETN_I),
    .CE_I(CE_I),
    .set_i(FAULT_COND_I),
    .clr_i(rd_clr),
    .flag_o(flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data decode

  always_comb
  begin
    rd_addr = (q.st == pmf_pkg::PMF_RDATA_ACK) ? q.ptr + 8'h01 : q.ptr;
    rd_byte = 8'h00;
    if (rd_addr == `PMF_FAULT_OFS)
    begin
      rd_byte[`PMF_UV_BIT] = flags.undervolt;
      rd_byte[`PMF_OV_BIT] = flags.overvolt;
      rd_byte[`PMF_TH_BIT] = flags.thermal;
    end
    else if (rd_addr == `PMF_CID_OFS)
    begin
      rd_byte[4:0] = CONFIG_ID_I;
    end
    else if (rd_addr == `PMF_SHARED_OFS)
    begin
      rd_byte[`PMF_STEP_MSB:`PMF_STEP_LSB] = q.step_sel;
      rd_byte[`PMF_DRV_MSB:`PMF_DRV_LSB] = q.drv;
    end
    else if (rd_addr == `PMF_CH0_OFS)
    begin
      rd_byte = q.ch0_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus framing and register updates

  always_comb
  begin
    d = q;
    rd_clr = 1'b0;
    scl_rise = ~q.scl_p & SCL_I;
    scl_fall = q.scl_p & ~SCL_I;
    start_cond = q.scl_p & SCL_I & q.sda_p & ~SDA_I;
    stop_cond = q.scl_p & SCL_I & ~q.sda_p & SDA_I;
    // coarse codes past full scale are reserved; hold the output at full scale
    wr_applied = (!q.step_sel[0] && q.sh > `PMF_COARSE_MAX_CODE) ? `PMF_COARSE_MAX_CODE : q.sh;
    d.scl_p = SCL_I;
    d.sda_p = SDA_I;
    if (start_cond)
    begin
      d.st = pmf_pkg::PMF_ADDR;
      d.cnt = 4'h0;
      d.sda_oen = 1'b1;
    end
    else if (stop_cond)
    begin
      d.st = pmf_pkg::PMF_IDLE;
      d.sda_oen = 1'b1;
    end
    else
    begin
      case (q.st)
        pmf_pkg::PMF_ADDR, pmf_pkg::PMF_REG, pmf_pkg::PMF_WDATA:
        begin
          if (scl_rise)
          begin
            d.sh = {q.sh[6:0], SDA_I};
            d.cnt = q.cnt + 4'h1;
          end
          else if (scl_fall && q.cnt == `PMF_BYTE_BITS)
          begin
            d.sda_oen = 1'b0;
            if (q.st == pmf_pkg::PMF_ADDR)
            begin
              d.rw = q.sh[0];
              d.st = pmf_pkg::PMF_ADDR_ACK;
              if (q.sh[7:1] != DEV_ADDR)
              begin
                d.st = pmf_pkg::PMF_IDLE;
                d.sda_oen = 1'b1;
              end
            end
            else if (q.st == pmf_pkg::PMF_REG)
            begin
              d.ptr = q.sh;
              d.st = pmf_pkg::PMF_REG_ACK;
            end
            else
            begin
              d.ptr = q.ptr + 8'h01;
              d.st = pmf_pkg::PMF_WDATA_ACK;
              if (q.ptr == `PMF_SHARED_OFS)
              begin
                d.step_sel = q.sh[`PMF_STEP_MSB:`PMF_STEP_LSB];
                d.drv = q.sh[`PMF_DRV_MSB:`PMF_DRV_LSB];
              end
              else if (q.ptr == `PMF_CH0_OFS)
              begin
                d.ch0_code = q.sh;
                d.ch0_step = q.step_sel[0];
                d.ch0_applied = wr_applied;
                // output in 12.5 mV units: coarse codes count double
                d.ch0_units = (q.step_sel[0] ? {1'b0, wr_applied} : {wr_applied, 1'b0})
                  + `PMF_BASE_UNITS;
              end
            end
          end
        end
        pmf_pkg::PMF_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            d.cnt = 4'h0;
            if (q.rw)
            begin
              d.tx = rd_byte;
              d.sda_oen = rd_byte[7];
              rd_clr = (rd_addr == `PMF_FAULT_OFS);
              d.st = pmf_pkg::PMF_RDATA;
            end
            else
            begin
              d.sda_oen = 1'b1;
              d.st = pmf_pkg::PMF_REG;
            end
          end
        end
        pmf_pkg::PMF_REG_ACK, pmf_pkg::PMF_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            d.sda_oen = 1'b1;
            d.cnt = 4'h0;
            d.st = pmf_pkg::PMF_WDATA;
          end
        end
        pmf_pkg::PMF_RDATA:
        begin
          if (scl_rise)
          begin
            d.cnt = q.cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (q.cnt == `PMF_BYTE_BITS)
            begin
              d.sda_oen = 1'b1;
              d.st = pmf_pkg::PMF_RDATA_ACK;
            end
            else
            begin
              d.tx = {q.tx[6:0], 1'b0};
              d.sda_oen = q.tx[6];
            end
          end
        end
        pmf_pkg::PMF_RDATA_ACK:
        begin
          if (scl_rise)
          begin
            d.nack = SDA_I;
          end
          else if (scl_fall)
          begin
            if (!q.nack)
            begin
              d.ptr = rd_addr;
              d.tx = rd_byte;
              d.sda_oen = rd_byte[7];
              rd_clr = (rd_addr == `PMF_FAULT_OFS);
              d.cnt = 4'h0;
              d.st = pmf_pkg::PMF_RDATA;
            end
            else
            begin
              d.st = pmf_pkg::PMF_IDLE;
            end
          end
        end
        default:
        begin
          d.sda_oen = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      q <= BANK_RST;
    end
    else if (CE_I)
    begin
      q <= d;
    end
  end

  assign SDA_O = q.sda_o;
  assign SDA_OEN_O = q.sda_oen;
  assign FAULT_FLAGS_O = flags;
  assign STEP_SELECT_O = q.step_sel;
  assign DRIVE_TRIM_O = q.drv;
  assign CH0_STEP_O = q.ch0_step;
  assign CH0_TARGET_CODE_O = q.ch0_applied;
  assign CH0_TARGET_UNITS_O = q.ch0_units;

endmodule

`default_nettype wire

// [pmf_regbank_properties.sv]
// assertions on the pins of the fault and regulator configuration bank
// assumes one clock domain; bound to every pmf_regbank instance
`timescale 1ns/1ps
`default_nettype none
module pmf_regbank_properties
(
  input wire logic CLK_SYS_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic SCL_I,
  input wire pmf_pkg::pmf_fault_s FAULT_COND_I,
  input wire pmf_pkg::pmf_fault_s FAULT_FLAGS_O,
  input wire logic [3:0] STEP_SELECT_O,
  input wire logic CH0_STEP_O,
  input wire logic [7:0] CH0_TARGET_CODE_O,
  input wire logic [8:0] CH0_TARGET_UNITS_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  // the previous edge saw scl low right after high
  sequence scl_fell_s;
    $past(SCL_I, 2) && !$past(SCL_I);
  endsequence
  a_uv_flag_sets: assert property (CE_I && FAULT_COND_I.undervolt |=> FAULT_FLAGS_O.undervolt)
    else $error("uv flag not set");
  a_ov_flag_sets: assert property (CE_I && FAULT_COND_I.overvolt |=> FAULT_FLAGS_O.overvolt)
    else $error("ov flag not set");
  a_th_flag_sets: assert property (CE_I && FAULT_COND_I.thermal |=> FAULT_FLAGS_O.thermal)
    else $error("thermal flag not set");
  a_clear_on_read: assert property (|(~FAULT_FLAGS_O & $past(FAULT_FLAGS_O)) |-> scl_fell_s)
    else $error("flag cleared off a read");
  a_cfg_on_fall: assert property ($changed(STEP_SELECT_O) |-> scl_fell_s)
    else $error("step select changed off the bus");
  a_ch0_step_latch: assert property ($changed(CH0_STEP_O) |-> CH0_STEP_O == $past(STEP_SELECT_O[0]))
    else $error("ch0 step not the select in force");
  a_units_formula: assert property (CH0_TARGET_UNITS_O ==
    9'h028 + (CH0_STEP_O ? {1'b0, CH0_TARGET_CODE_O} : {CH0_TARGET_CODE_O, 1'b0}))
    else $error("ch0 units wrong");
  a_coarse_limit: assert property (!CH0_STEP_O |-> CH0_TARGET_CODE_O <= 8'hc8)
    else $error("coarse code above full scale");
endmodule
bind pmf_regbank pmf_regbank_properties u_props (.CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .CE_I(CE_I),
  .SCL_I(SCL_I), .FAULT_COND_I(FAULT_COND_I), .FAULT_FLAGS_O(FAULT_FLAGS_O), .STEP_SELECT_O(STEP_SELECT_O),
  .CH0_STEP_O(CH0_STEP_O), .CH0_TARGET_CODE_O(CH0_TARGET_CODE_O), .CH0_TARGET_UNITS_O(CH0_TARGET_UNITS_O));
`default_nettype wire

// [pmf_host.sv]
// serial bus host model: drives scl and its share of sda, reads the wire
// assumes a pull-up on sda; every scl phase lasts at least two clocks
`timescale 1ns/1ps
`default_nettype none
module pmf_host
#(
  parameter logic [6:0] ADDR = 7'h2a
)
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic bit_io(input logic b, output logic q);
    sda_o = b;
    tk(2);
    scl_o = 1'b1;
    tk(2);
    q = sda_i;
    scl_o = 1'b0;
    tk(1);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], q[i]);
    end
    bit_io(m, a);
  endtask
  task automatic start();
    sda_o = 1'b1;
    tk(2);
    scl_o = 1'b1;
    tk(2);
    sda_o = 1'b0;
    tk(2);
    scl_o = 1'b0;
    tk(2);
  endtask
  task automatic stop();
    sda_o = 1'b0;
    tk(2);
    scl_o = 1'b1;
    tk(2);
    sda_o = 1'b1;
    tk(2);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(p, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    nak = a0 | a1 | a2;
  endtask
  // single byte read, ended by a host not-acknowledge
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] q;
    logic a;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a);
    xfer(p, 1'b1, q, a);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, a);
    xfer(8'hff, 1'b1, d, a);
    stop();
  endtask
endmodule
`default_nettype wire

// [pmic_fault_flags_regulator_cfg_test.sv]
// self-checking bench of the fault and regulator configuration bank
// drives the serial bus through pmf_host; sda has a pull-up
`timescale 1ns/1ps
`default_nettype none
module pmic_fault_flags_regulator_cfg_test;
  logic clk, rst_n, ce, scl, hsda, oen, sdo, c0s, sda;
  pmf_pkg::pmf_fault_s cond, flags;
  logic [4:0] chip_config_id;
  logic [3:0] stp;
  logic [1:0] drv;
  logic [7:0] c0c, r;
  logic [8:0] c0u;
  logic [31:0] seed = 32'h00004bfd;
  int errors = 0;
  int total_checks = 0;
  logic [7:0] tab [4] = '{8'hc8, 8'hc9, 8'hff, 8'h00};
  assign sda = hsda & (oen | sdo);
  pmf_regbank dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .CE_I(ce), .SCL_I(scl), .SDA_I(sda), .SDA_O(sdo),
    .SDA_OEN_O(oen), .FAULT_COND_I(cond), .CONFIG_ID_I(chip_config_id), .FAULT_FLAGS_O(flags), .STEP_SELECT_O(stp),
    .DRIVE_TRIM_O(drv), .CH0_STEP_O(c0s), .CH0_TARGET_CODE_O(c0c), .CH0_TARGET_UNITS_O(c0u));
  pmf_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
  ////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] code_exp(input logic s, input logic [7:0] c);
    return (!s && c > 8'hc8) ? 8'hc8 : c;
  endfunction
  function automatic logic [8:0] units(input logic s, input logic [7:0] c);
    return 9'h028 + (s ? {1'b0, c} : {c, 1'b0});
  endfunction
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    final_report();
  end
  initial
  begin
    logic [7:0] v, c;
    logic a, p;
    logic [8:0] u;
    rst_n = 1'b0;
    ce = 1'b1;
    cond = '0;
    chip_config_id = 5'h00;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    host.tk(2);
    chk("units", 9'h028, c0u);
    chk("step", 9'h000, 9'({stp, drv}));
    host.rd(8'h07, r);
    chk("shared", 9'h000, 9'(r));
    $display("reset test done");
    v = rnd();
    chip_config_id = v[4:0];
    host.wr(8'h06, 8'hff, a);
    chk("ack", 9'h000, 9'(a));
    host.rd(8'h06, r);
    chk("id", 9'(chip_config_id), 9'(r));
    $display("id test done");
    for (int i = 0; i < 3; i++)
    begin
      cond = pmf_pkg::pmf_fault_s'(3'h1 << i);
      host.tk(3);
      cond = '0;
      host.tk(2);
      chk("flag", 9'(3'h1 << i), 9'(flags));
      host.rd(8'h05, r);
      chk("fault", 9'(3'h1 << i), 9'(r));
      chk("cleared", 9'h000, 9'(flags));
    end
    // a fault seen while the clock enable is low must not be captured
    ce = 1'b0;
    cond = pmf_pkg::pmf_fault_s'(3'h4);
    host.tk(3);
    cond = '0;
    ce = 1'b1;
    host.tk(2);
    chk("frozen", 9'h000, 9'(flags));
    // a fault still present when the read clears the flags keeps its flag
    cond = pmf_pkg::pmf_fault_s'(3'h1);
    host.rd(8'h05, r);
    chk("held", 9'h001, 9'(r));
    cond = '0;
    host.tk(2);
    chk("set wins", 9'h001, 9'(flags));
    host.rd(8'h05, r);
    chk("reread", 9'h001, 9'(r));
    chk("recleared", 9'h000, 9'(flags));
    $display("fault test done");
    for (int n = 0; n < 12; n++)
    begin
      v = rnd();
      v[2] = n[1];
      c = n < 4 ? tab[n] : rnd();
      p = c0s;
      u = c0u;
      host.wr(8'h07, v, a);
      chk("deferred", 9'(p), 9'(c0s));
      chk("deferred units", u, c0u);
      chk("cfg", 9'(v[5:0]), 9'({stp, drv}));
      host.rd(8'h07, r);
      chk("cfg rd", 9'(v & 8'h3f), 9'(r));
      host.wr(8'h08, c, a);
      chk("ch0 step", 9'(v[2]), 9'(c0s));
      chk("ch0 code", 9'(code_exp(v[2], c)), 9'(c0c));
      chk("ch0 units", units(v[2], code_exp(v[2], c)), c0u);
      host.rd(8'h08, r);
      chk("ch0 rd", 9'(c), 9'(r));
    end
    host.rd(8'h20, r);
    chk("unmapped", 9'h000, 9'(r));
    $display("config test done");
    final_report();
  end
endmodule
`default_nettype wire
